// File: verilog/saxis_top.sv
// axis status flags, encoder deviation stop and current mode control
// assumes synchronous inputs on CORE_CLK and a one-cycle strobe port
//
// Strobed register access is this design's own decision.
`timescale 1ns/100ps
`default_nettype none
`include "saxis_params.svh"

module saxis_top #(
	parameter int TICK_CYCLES = `SAX_UNIT_MS * `SAX_CLK_KHZ,
	parameter int STILL_CYCLES = 1 << `SAX_STILL_LOG2
) (
	input wire logic CORE_CLK, // core clock
	input wire logic RSTN, // sync reset, low
	input wire logic [7:0] ADDR, // register index
	input wire logic [31:0] WDATA, // write data
	input wire logic WR, // write strobe
	input wire logic RD, // read strobe
	output logic [31:0] RDATA, // read data, next cycle
	input wire logic STALL_REACHED, // load threshold hit
	input wire logic OT_SHUTDOWN, // overtemp shutdown
	input wire logic OT_PREWARN, // overtemp warning
	input wire logic SHORT_A, // coil A short
	input wire logic SHORT_B, // coil B short
	input wire logic CHOP_A, // coil A chopper event
	input wire logic CHOP_B, // coil B chopper event
	input wire logic POL_A, // coil A polarity
	input wire logic POL_B, // coil B polarity
	input wire logic STEP_IN, // step input
	input wire logic ENABLE_IN, // enable input
	input wire logic ENC_UP, // encoder count up
	input wire logic ENC_DN, // encoder count down
	input wire logic [31:0] ACTUAL_POS, // signed position
	input wire logic [9:0] ANGLE_IN, // rotor sensor angle
	output logic RUN_CURRENT, // 1 run, 0 hold or off
	output logic DRIVER_EN, // driver stages on
	output logic MOTOR_STOP, // deviation stop
	output logic IRQ // level interrupt
);
	import saxis_pkg::*;

	default clocking cb @(posedge CORE_CLK); endclocking
	default disable iff (!RSTN);

	// register file state
	logic [31:0] enc;
	logic [31:0] pre;
	logic [31:0] dev_lim;
	logic [15:0] pdd;
	logic [9:0] ang;
	saxis_mode_e mode;
	logic [`SAX_IRQ_W-1:0] ist;
	logic [`SAX_IRQ_W-1:0] imsk;
	logic [31:0] next_enc;
	logic [31:0] next_pre;
	logic [31:0] next_dev_lim;
	logic [15:0] next_pdd;
	saxis_mode_e next_mode;
	logic [`SAX_IRQ_W-1:0] next_ist;
	logic [`SAX_IRQ_W-1:0] next_imsk;
	logic [31:0] next_rdata;
	logic next_irq;

	// monitor state
	logic [7:0] err;
	logic [7:0] next_err;
	logic seen_a;
	logic seen_b;
	logic pol_a_q;
	logic pol_b_q;
	logic ol_a;
	logic ol_b;
	logic next_seen_a;
	logic next_seen_b;
	logic next_ol_a;
	logic next_ol_b;
	logic step_q;
	logic [31:0] still_cnt;
	logic [31:0] next_still_cnt;

	// timer and current state
	logic [31:0] tick_cnt;
	logic [15:0] idle_ticks;
	logic auto_run;
	saxis_cur_e cur;
	logic [31:0] next_tick_cnt;
	logic [15:0] next_idle_ticks;
	logic next_auto_run;
	saxis_cur_e next_cur;
	logic next_stop;

	logic step_edge;
	logic idle_done;
	logic [32:0] diff;
	logic [32:0] dev_abs;
	logic dev_hit;
	logic [`SAX_IRQ_W-1:0] ev;

	assign step_edge = STEP_IN & ~step_q;
	assign idle_done = idle_ticks >= pdd;

	// absolute deviation, 33 bits so no overflow
	always_comb begin
		diff = {ACTUAL_POS[31], ACTUAL_POS} - {enc[31], enc};
		dev_abs = diff[32] ? (33'h0 - diff) : diff;
		dev_hit = (dev_lim != 32'h0) && (dev_abs > {1'b0, dev_lim});
	end

	// driver status monitor
	always_comb begin
		next_seen_a = seen_a | CHOP_A;
		next_seen_b = seen_b | CHOP_B;
		next_ol_a = ol_a;
		next_ol_b = ol_b;
		if (POL_A != pol_a_q) begin
			next_ol_a = ~seen_a;
			next_seen_a = CHOP_A;
		end
		if (POL_B != pol_b_q) begin
			next_ol_b = ~seen_b;
			next_seen_b = CHOP_B;
		end
		if (step_edge) begin
			next_still_cnt = 32'h0;
		end else if (still_cnt < 32'(STILL_CYCLES)) begin
			next_still_cnt = still_cnt + 32'h1;
		end else begin
			next_still_cnt = still_cnt;
		end
		next_err = 8'h00;
		next_err[`SAX_B_STALL] = STALL_REACHED;
		next_err[`SAX_B_OT] = OT_SHUTDOWN;
		next_err[`SAX_B_OTPW] = OT_PREWARN;
		next_err[`SAX_B_SGA] = SHORT_A;
		next_err[`SAX_B_SGB] = SHORT_B;
		next_err[`SAX_B_OLA] = next_ol_a;
		next_err[`SAX_B_OLB] = next_ol_b;
		next_err[`SAX_B_STILL] = next_still_cnt >= 32'(STILL_CYCLES);
	end

	always_ff @(posedge CORE_CLK) begin
		if (!RSTN) begin
			err <= 8'h00;
			seen_a <= 1'b0;
			seen_b <= 1'b0;
			ol_a <= 1'b0;
			ol_b <= 1'b0;
			pol_a_q <= 1'b0;
			pol_b_q <= 1'b0;
			step_q <= 1'b0;
			still_cnt <= 32'h0;
		end else begin
			err <= next_err;
			seen_a <= next_seen_a;
			seen_b <= next_seen_b;
			ol_a <= next_ol_a;
			ol_b <= next_ol_b;
			pol_a_q <= POL_A;
			pol_b_q <= POL_B;
			step_q <= STEP_IN;
			still_cnt <= next_still_cnt;
		end
	end

	// standstill timer and current selection
	always_comb begin
		next_tick_cnt = tick_cnt + 32'h1;
		next_idle_ticks = idle_ticks;
		if (tick_cnt >= 32'(TICK_CYCLES - 1)) begin
			next_tick_cnt = 32'h0;
			if (idle_ticks != 16'hFFFF) begin
				next_idle_ticks = idle_ticks + 16'h1;
			end
		end
		next_auto_run = auto_run;
		if (step_edge) begin
			next_tick_cnt = 32'h0;
			next_idle_ticks = 16'h0;
			next_auto_run = 1'b1;
		end else if (idle_done) begin
			next_auto_run = 1'b0;
		end
		case (mode)
			MODE_ENABLE: next_cur = ENABLE_IN ? CUR_RUN : CUR_HOLD;
			MODE_AUTO: next_cur = (step_edge | next_auto_run) ? CUR_RUN : CUR_HOLD;
			MODE_RUN: next_cur = CUR_RUN;
			MODE_AUTO_EN: begin
				if (!ENABLE_IN) begin
					next_cur = CUR_OFF;
				end else begin
					next_cur = next_auto_run ? CUR_RUN : CUR_HOLD;
				end
			end
			MODE_RUN_EN: next_cur = ENABLE_IN ? CUR_RUN : CUR_OFF;
			default: next_cur = (idle_done & ~step_edge) ? CUR_HOLD : CUR_RUN;
		endcase
		next_stop = dev_hit;
	end

	always_ff @(posedge CORE_CLK) begin
		if (!RSTN) begin
			tick_cnt <= 32'h0;
			idle_ticks <= 16'h0;
			auto_run <= 1'b0;
			cur <= CUR_RUN;
			RUN_CURRENT <= 1'b0;
			DRIVER_EN <= 1'b0;
			MOTOR_STOP <= 1'b0;
		end else begin
			tick_cnt <= next_tick_cnt;
			idle_ticks <= next_idle_ticks;
			auto_run <= next_auto_run;
			cur <= next_cur;
			RUN_CURRENT <= next_cur == CUR_RUN;
			DRIVER_EN <= next_cur != CUR_OFF;
			MOTOR_STOP <= next_stop;
		end
	end

	// register access and interrupt status
	always_comb begin
		ev = '0;
		ev[`SAX_I_FLAG] = |(next_err & ~err);
		ev[`SAX_I_DEV] = next_stop & ~MOTOR_STOP;
		ev[`SAX_I_PDN] = (next_cur == CUR_HOLD) && (cur == CUR_RUN);
		next_enc = enc;
		if (ENC_UP & ~ENC_DN) begin
			next_enc = enc + 32'h1;
		end else if (ENC_DN & ~ENC_UP) begin
			next_enc = enc - 32'h1;
		end
		next_pre = pre;
		next_dev_lim = dev_lim;
		next_pdd = pdd;
		next_mode = mode;
		next_imsk = imsk;
		next_ist = ist;
		if (WR) begin
			case (ADDR)
				`SAX_A_ENC: next_enc = WDATA;
				`SAX_A_PRE: next_pre = WDATA;
				`SAX_A_DEV: next_dev_lim = WDATA;
				`SAX_A_PDD: next_pdd = WDATA[15:0];
				`SAX_A_MODE: next_mode = saxis_mode_e'(WDATA[2:0]);
				`SAX_A_IST: next_ist = ist & ~WDATA[`SAX_IRQ_W-1:0];
				`SAX_A_IMSK: next_imsk = WDATA[`SAX_IRQ_W-1:0];
				default: next_ist = ist;
			endcase
		end
		next_ist = next_ist | ev;
		next_irq = |(next_ist & next_imsk);
		next_rdata = 32'h0;
		if (RD) begin
			case (ADDR)
				`SAX_A_ERR: next_rdata = {24'h0, err};
				`SAX_A_ENC: next_rdata = enc;
				`SAX_A_PRE: next_rdata = pre;
				`SAX_A_DEV: next_rdata = dev_lim;
				`SAX_A_PDD: next_rdata = {16'h0, pdd};
				`SAX_A_ANG: next_rdata = {22'h0, ang};
				`SAX_A_MODE: next_rdata = {29'h0, mode};
				`SAX_A_IST: next_rdata = {29'h0, ist};
				`SAX_A_IMSK: next_rdata = {29'h0, imsk};
				default: next_rdata = 32'h0;
			endcase
		end
	end

	always_ff @(posedge CORE_CLK) begin
		if (!RSTN) begin
			enc <= 32'h0;
			pre <= 32'h0;
			dev_lim <= 32'h0;
			pdd <= `SAX_RST_PDD;
			ang <= 10'h000;
			mode <= saxis_mode_e'(`SAX_RST_MODE);
			ist <= '0;
			imsk <= '0;
			IRQ <= 1'b0;
			RDATA <= 32'h0;
		end else begin
			enc <= next_enc;
			pre <= next_pre;
			dev_lim <= next_dev_lim;
			pdd <= next_pdd;
			ang <= ANGLE_IN;
			mode <= next_mode;
			ist <= next_ist;
			imsk <= next_imsk;
			IRQ <= next_irq;
			RDATA <= next_rdata;
		end
	end

	// checks
	sequence s_step_auto;
		(mode == MODE_AUTO) && step_edge;
	endsequence
	sequence s_run_out;
		RUN_CURRENT && DRIVER_EN;
	endsequence
	sequence s_hold_out;
		!RUN_CURRENT && DRIVER_EN;
	endsequence

	property p_stall;
		STALL_REACHED |=> err[`SAX_B_STALL] ##1 1'b1;
	endproperty
	a_stall: assert property (p_stall) else $error("stall flag missing");
	property p_ot;
		$changed(OT_SHUTDOWN) |=> err[`SAX_B_OT] == $past(OT_SHUTDOWN);
	endproperty
	a_ot: assert property (p_ot) else $error("overtemp flag wrong");
	property p_otpw;
		!OT_PREWARN |=> !err[`SAX_B_OTPW];
	endproperty
	a_otpw: assert property (p_otpw) else $error("prewarn flag stuck");
	property p_short;
		1'b1 |=> err[`SAX_B_SGB:`SAX_B_SGA] == $past({SHORT_B, SHORT_A});
	endproperty
	a_short: assert property (p_short) else $error("short flags wrong");
	property p_still;
		step_edge |=> !err[`SAX_B_STILL] [*8];
	endproperty
	a_still: assert property (p_still) else $error("standstill flag after step");
	property p_dev;
		dev_hit |=> MOTOR_STOP;
	endproperty
	a_dev: assert property (p_dev) else $error("deviation stop missing");
	property p_dev_off;
		dev_lim == 32'h0 |=> !MOTOR_STOP;
	endproperty
	a_dev_off: assert property (p_dev_off) else $error("stop with limit zero");
	property p_mode1;
		mode == MODE_ENABLE |=> RUN_CURRENT == $past(ENABLE_IN) && DRIVER_EN;
	endproperty
	a_mode1: assert property (p_mode1) else $error("mode 1 current wrong");
	property p_mode2;
		s_step_auto |=> s_run_out;
	endproperty
	a_mode2: assert property (p_mode2) else $error("mode 2 no run on step");
	property p_mode3;
		mode == MODE_RUN |=> s_run_out;
	endproperty
	a_mode3: assert property (p_mode3) else $error("mode 3 not run");
	property p_mode5;
		mode == MODE_RUN_EN |=> DRIVER_EN == $past(ENABLE_IN) && RUN_CURRENT == DRIVER_EN;
	endproperty
	a_mode5: assert property (p_mode5) else $error("mode 5 enable wrong");
	property p_open_a;
		POL_A != pol_a_q |=> err[`SAX_B_OLA] == !$past(seen_a);
	endproperty
	a_open_a: assert property (p_open_a) else $error("open load A flag wrong");
	property p_open_b;
		POL_B != pol_b_q |=> err[`SAX_B_OLB] == !$past(seen_b);
	endproperty
	a_open_b: assert property (p_open_b) else $error("open load B flag wrong");
	property p_angle;
		RD && ADDR == `SAX_A_ANG |=> RDATA == {22'h0, $past(ang)};
	endproperty
	a_angle: assert property (p_angle) else $error("angle readback wrong");
	property p_mode0;
		mode == MODE_NORMAL && idle_done && !step_edge |=> s_hold_out;
	endproperty
	a_mode0: assert property (p_mode0) else $error("mode 0 no standby current");
	property p_mode2_hold;
		mode == MODE_AUTO && idle_done && !step_edge |=> s_hold_out;
	endproperty
	a_mode2_hold: assert property (p_mode2_hold) else $error("mode 2 no hold after delay");
	property p_mode4;
		mode == MODE_AUTO_EN && !ENABLE_IN |=> !DRIVER_EN && !RUN_CURRENT;
	endproperty
	a_mode4: assert property (p_mode4) else $error("mode 4 driver not off");
	property p_dev_irq;
		ev[`SAX_I_DEV] |=> ist[`SAX_I_DEV];
	endproperty
	a_dev_irq: assert property (p_dev_irq) else $error("deviation status lost");
endmodule

`default_nettype wire

// File: verilog/saxis_params.svh
// constants for the stepper axis status and current mode block
// assumes a single 20 MHz core clock and a register index port
`ifndef SAXIS_PARAMS_SVH
`define SAXIS_PARAMS_SVH

`define SAX_A_ERR 8'hD0
`define SAX_A_ENC 8'hD1
`define SAX_A_PRE 8'hD2
`define SAX_A_DEV 8'hD4
`define SAX_A_PDD 8'hD6
`define SAX_A_ANG 8'hD7
`define SAX_A_MODE 8'hFE
`define SAX_A_IST 8'hE0
`define SAX_A_IMSK 8'hE1

`define SAX_B_STALL 0
`define SAX_B_OT 1
`define SAX_B_OTPW 2
`define SAX_B_SGA 3
`define SAX_B_SGB 4
`define SAX_B_OLA 5
`define SAX_B_OLB 6
`define SAX_B_STILL 7

`define SAX_I_FLAG 0
`define SAX_I_DEV 1
`define SAX_I_PDN 2
`define SAX_IRQ_W 3

`define SAX_RST_PDD 16'h00C8
`define SAX_RST_MODE 3'h0

`define SAX_CLK_KHZ 20000
`define SAX_UNIT_MS 10
`define SAX_STILL_LOG2 20

`endif

// File: verilog/saxis_pkg.sv
// types for the stepper axis status and current mode block
// assumes the constants header for numbers
package saxis_pkg;
	typedef enum logic [2:0] {
		MODE_NORMAL = 3'h0,
		MODE_ENABLE = 3'h1,
		MODE_AUTO = 3'h2,
		MODE_RUN = 3'h3,
		MODE_AUTO_EN = 3'h4,
		MODE_RUN_EN = 3'h5
	} saxis_mode_e;
	typedef enum logic [2:0] {
		CUR_OFF = 3'b001,
		CUR_HOLD = 3'b010,
		CUR_RUN = 3'b100
	} saxis_cur_e;
endpackage

// File: verification/saxis_far.sv
// far-side model: step source, enable pin and driver status pins
// assumes bench requests change just after a rising clock edge
`timescale 1ns/100ps
`default_nettype none
module saxis_far (
	input wire logic clk, // core clock
	input wire logic step_go, // one step wanted
	input wire logic en_req, // enable level wanted
	input wire logic [4:0] flt, // stall, ot, warn, short a, b
	input wire logic [1:0] chop, // chopper events a, b
	input wire logic [1:0] pol, // coil polarity a, b
	output logic step, // step pin, idle low
	output logic en, // enable pin
	output logic [4:0] flt_o, // status pins
	output logic [1:0] chop_o, // chopper pins
	output logic [1:0] pol_o // polarity pins
);
	always_ff @(posedge clk) begin
		step <= step_go;
		en <= en_req;
		flt_o <= flt;
		chop_o <= chop;
		pol_o <= pol;
	end
endmodule
`default_nettype wire

// File: verification/testbench.sv
// bench for the stepper axis status and current mode block
// assumes the far-side model and shortened tick counts
`timescale 1ns/100ps
`default_nettype none
module testbench;
	logic clk = 0, rstn = 0, wr = 0, rd = 0, go = 0, en = 0;
	logic [7:0] addr = 0;
	logic [31:0] wdata = 0, pos = 0, rdata, q;
	logic [4:0] flt = 0, flt_p;
	logic [1:0] chop = 0, pol = 0, chop_p, pol_p;
	logic [9:0] ang = 0;
	logic step_p, en_p, run, drv, stop, irq, run_w, drv_w, stop_w, irq_w, eup = 0, edn = 0;
	logic [31:0] rdata_w;
	int errors = 0, comparisons = 0, cyc = 0;
	always #25 clk = ~clk;
	saxis_top #(.TICK_CYCLES(4), .STILL_CYCLES(16)) i_dut (
		.CORE_CLK(clk), .RSTN(rstn), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd),
		.RDATA(rdata_w), .STALL_REACHED(flt_p[0]), .OT_SHUTDOWN(flt_p[1]),
		.OT_PREWARN(flt_p[2]), .SHORT_A(flt_p[3]), .SHORT_B(flt_p[4]),
		.CHOP_A(chop_p[0]), .CHOP_B(chop_p[1]), .POL_A(pol_p[0]), .POL_B(pol_p[1]),
		.STEP_IN(step_p), .ENABLE_IN(en_p), .ENC_UP(eup), .ENC_DN(edn),
		.ACTUAL_POS(pos), .ANGLE_IN(ang), .RUN_CURRENT(run_w), .DRIVER_EN(drv_w),
		.MOTOR_STOP(stop_w), .IRQ(irq_w));
	saxis_far i_far (.clk(clk), .step_go(go), .en_req(en), .flt(flt), .chop(chop),
		.pol(pol), .step(step_p), .en(en_p), .flt_o(flt_p), .chop_o(chop_p), .pol_o(pol_p));
	// outputs copied at the falling edge, where they are settled
	always @(negedge clk) begin
		rdata <= rdata_w;
		run <= run_w;
		drv <= drv_w;
		stop <= stop_w;
		irq <= irq_w;
	end
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
	endtask
	task automatic chk(input string s, input logic [31:0] g, input logic [31:0] e);
		comparisons++;
		if (g !== e) begin
			errors++;
			$display("mismatch %s expected %h seen %h", s, e, g);
		end
	endtask
	task automatic wreg(input logic [7:0] a, input logic [31:0] d);
		addr <= a;
		wdata <= d;
		wr <= 1;
		tick(1);
		wr <= 0;
		tick(1);
	endtask
	task automatic rreg(input logic [7:0] a);
		addr <= a;
		rd <= 1;
		tick(1);
		rd <= 0;
		tick(1);
		q = rdata;
	endtask
	task automatic step1;
		go <= 1;
		tick(1);
		go <= 0;
		tick(4);
	endtask
	task automatic t_regs;
		rreg(8'hD6);
		chk("delay", q, 32'hC8);
		rreg(8'hFE);
		chk("mode", q, 32'h0);
		ang <= 10'h3FF;
		wreg(8'hD7, 32'h0);
		rreg(8'hD7);
		chk("angle", q, 32'h3FF);
		wreg(8'hD0, 32'h7F);
		tick(8);
		rreg(8'hD0);
		chk("errword", q, 32'h80);
		rreg(8'hC0);
		chk("unmapped", q, 32'h0);
		$display("test regs done");
	endtask
	task automatic t_flags;
		for (int i = 0; i < 5; i++) begin
			flt <= 5'h1 << i;
			tick(3);
			rreg(8'hD0);
			chk("flag", {27'h0, q[4:0]}, 32'h1 << i);
		end
		flt <= 0;
		tick(3);
		rreg(8'hD0);
		chk("flagclr", {27'h0, q[4:0]}, 32'h0);
		pol <= 2'h3;
		tick(4);
		rreg(8'hD0);
		chk("openld", {30'h0, q[6:5]}, 32'h3);
		chop <= 2'h1;
		tick(2);
		chop <= 0;
		pol <= 0;
		tick(4);
		rreg(8'hD0);
		chk("openld2", {30'h0, q[6:5]}, 32'h2);
		step1;
		rreg(8'hD0);
		chk("still0", {31'h0, q[7]}, 32'h0);
		tick(14);
		rreg(8'hD0);
		chk("still1", {31'h0, q[7]}, 32'h1);
		$display("test flags done");
	endtask
	task automatic t_dev;
		pos <= 32'd100;
		wreg(8'hD4, 32'h0);
		wreg(8'hE1, 32'h2);
		tick(4);
		chk("stopoff", {31'h0, stop}, 32'h0);
		wreg(8'hD4, 32'd100);
		tick(4);
		chk("stopeq", {31'h0, stop}, 32'h0);
		wreg(8'hD4, 32'd99);
		tick(4);
		chk("stop", {31'h0, stop}, 32'h1);
		chk("irq", {31'h0, irq}, 32'h1);
		wreg(8'hD1, 32'd100);
		rreg(8'hD1);
		chk("enc", q, 32'd100);
		eup <= 1;
		tick(3);
		eup <= 0;
		edn <= 1;
		tick(1);
		edn <= 0;
		rreg(8'hD1);
		chk("enccount", q, 32'd102);
		tick(2);
		chk("stopclr", {31'h0, stop}, 32'h0);
		wreg(8'hE0, 32'h2);
		tick(4);
		chk("irqclr", {31'h0, irq}, 32'h0);
		$display("test deviation done");
	endtask
	task automatic t_modes;
		wreg(8'hD6, 32'h4);
		step1;
		chk("m0", {30'h0, run, drv}, 32'h3);
		wreg(8'hFE, 32'h1);
		tick(4);
		chk("m1off", {30'h0, run, drv}, 32'h1);
		en <= 1;
		tick(4);
		chk("m1on", {30'h0, run, drv}, 32'h3);
		en <= 0;
		wreg(8'hFE, 32'h3);
		tick(30);
		chk("m3", {30'h0, run, drv}, 32'h3);
		wreg(8'hFE, 32'h5);
		tick(3);
		chk("m5off", {31'h0, drv}, 32'h0);
		en <= 1;
		tick(4);
		chk("m5on", {30'h0, run, drv}, 32'h3);
		en <= 0;
		wreg(8'hFE, 32'h2);
		tick(30);
		chk("m2idle", {30'h0, run, drv}, 32'h1);
		step1;
		chk("m2run", {30'h0, run, drv}, 32'h3);
		tick(30);
		chk("m2hold", {31'h0, run}, 32'h0);
		wreg(8'hFE, 32'h4);
		tick(3);
		chk("m4off", {31'h0, drv}, 32'h0);
		en <= 1;
		wreg(8'hE1, 32'h4);
		wreg(8'hE0, 32'h7);
		step1;
		chk("m4run", {30'h0, run, drv}, 32'h3);
		chk("irqpdn0", {31'h0, irq}, 32'h0);
		tick(30);
		chk("m4hold", {30'h0, run, drv}, 32'h1);
		chk("irqpdn", {31'h0, irq}, 32'h1);
		$display("test modes done");
	endtask
	task automatic wrap_up;
		$display("comparisons %0d errors %0d", comparisons, errors);
		if (errors == 0 && comparisons > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask
	initial begin
		tick(8);
		rstn <= 1;
		tick(1);
		t_regs;
		t_flags;
		t_dev;
		t_modes;
		wrap_up;
	end
	always @(posedge clk) begin
		cyc++;
		if (cyc == 5000) begin
			errors++;
			wrap_up;
		end
	end
endmodule
`default_nettype wire
